// *** verilog/seerp_pkg.sv ***
// Package for the serial EEPROM slave: sizes, address fields, timing.
// Assumes a 100 MHz system clock; the bus clock is sampled, not used as a clock.
package seerp_pkg;
  // ==========================================================
  // Array geometry
  localparam int          SEERP_ADDR_W   = 11;        // Byte address width
  localparam int          SEERP_DEPTH    = 2048;      // Bytes in the array
  localparam logic [10:0] SEERP_ADDR_MAX = 11'h7ff;   // Last address before wrap
  localparam logic [10:0] SEERP_ADDR_RST = 11'h000;   // Counter reset value
  localparam logic [7:0]  SEERP_BYTE_RST = 8'h00;     // Shift register reset value
  // ==========================================================
  // Slave address byte layout
  localparam int          SEERP_SA_FIX   = 7;         // Fixed one bit
  localparam int          SEERP_SA_CS_HI = 6;         // Chip select field top
  localparam int          SEERP_SA_CS_LO = 4;         // Chip select field bottom
  localparam int          SEERP_SA_UA_HI = 3;         // Upper address top
  localparam int          SEERP_SA_UA_LO = 1;         // Upper address bottom
  localparam int          SEERP_SA_RW    = 0;         // Direction bit
  localparam logic [2:0]  SEERP_CS_INV   = 3'h2;      // Middle select inverted
  localparam logic [2:0]  SEERP_LAST_BIT = 3'h7;      // Bit count of last bit
  localparam logic [2:0]  SEERP_BIT_RST  = 3'h0;      // Bit counter reset
  localparam logic [3:0]  SEERP_PAGE_MSK = 4'hf;      // Page write rolls low nibble
  // ==========================================================
  // Internal write cycle timing
  localparam int          SEERP_CLK_MHZ  = 100;       // System clock rate
  localparam int          SEERP_TWR_US   = 10000;     // Longest write cycle, us
  localparam int          SEERP_TWR_CYC  = SEERP_TWR_US * SEERP_CLK_MHZ;
  localparam int          SEERP_TMR_W    = 24;        // Busy timer width
  // ==========================================================
  // Protocol states, Gray coded in the order listed
  typedef enum logic [2:0] {
    SEERP_IDLE  = 3'b000,   // Waiting for a start
    SEERP_SADDR = 3'b001,   // Shifting in slave address
    SEERP_ACK   = 3'b011,   // Driving an acknowledge
    SEERP_WADDR = 3'b010,   // Shifting in word address
    SEERP_WDATA = 3'b110,   // Shifting in write data
    SEERP_RDATA = 3'b111,   // Shifting out read data
    SEERP_MACK  = 3'b101    // Sampling master acknowledge
  } seerp_state_type;
endpackage

// *** verilog/seerp_slave.sv ***
// Serial EEPROM two-wire slave: reads, writes, address counter, busy polling.
// Assumes bus clock and data come in as plain pins sampled by i_ref_clk.
// Behaviour
// - No acknowledge while write cycle runs
// - Acknowledge polling address once write done
// - Read begins like write, direction one
// - Counter holds last accessed address plus one
// - Read address acknowledged, byte sent MSB first
// - Random read returns byte at loaded address
// - Master acknowledge requests next byte
// - Counter wraps from 2047 to 0
// - Missing acknowledge stops data output
// - Slave address: one, selects, upper bits, direction
// - Upper bits join word address, eleven bits
// - Released line, receiver pulls ninth low
// - All traffic ignored during write cycle
`timescale 1ns/1ps
`default_nettype none
module seerp_slave
  import seerp_pkg::*;
#(
  parameter int TWR_CYCLES = SEERP_TWR_CYC   // Busy length in clocks
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Two-wire bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  // Device select straps
  input  wire logic [2:0] i_chip_select_inputs,
  // Status
  output logic            o_busy
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] scl_sync;   // Bus clock, two stages
  logic [1:0] sda_sync;   // Bus data, two stages
  logic [2:0] cs_meta;    // Select first stage
  logic [2:0] cs_sync;    // Select second stage
  logic       scl_d;      // Delayed synced clock
  logic       sda_d;      // Delayed synced data

  // Two flops on the bus pins and select straps; reset goes in unsynchronised
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      cs_meta  <= 3'h0;
      cs_sync  <= 3'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      cs_meta  <= i_chip_select_inputs;
      cs_sync  <= cs_meta;
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  // Bus events
  logic scl_rise;   // Sample point
  logic scl_fall;   // Change point
  logic start_ev;   // Data falls with clock high
  logic stop_ev;    // Data rises with clock high
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_ev = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_ev  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ==========================================================
  // Storage and state
  logic [7:0]              mem [SEERP_DEPTH];   // Array in flip-flops
  seerp_state_type         state;               // Protocol state
  seerp_state_type         ack_next;            // State after ack slot
  logic [7:0]              shreg;               // Shift register
  logic [2:0]              bitcnt;              // Bits done in byte
  logic [SEERP_ADDR_W-1:0] addr;                // Address counter
  logic [2:0]              upper;               // Upper bits from slave address
  logic                    wr_pend;             // Write data captured
  logic [SEERP_TMR_W-1:0]  tmr;                 // Busy timer
  logic                    drive_low;           // Pull data line low
  logic                    ack_held;            // Acknowledge slot already open

  // Slave address match against straps
  function automatic logic sa_match(input logic [7:0] sa, input logic [2:0] cs);
    sa_match = sa[SEERP_SA_FIX] & (sa[SEERP_SA_CS_HI:SEERP_SA_CS_LO] == (cs ^ SEERP_CS_INV));
  endfunction

  // Eleven-bit address from upper bits and word byte
  function automatic logic [SEERP_ADDR_W-1:0] join_addr(input logic [2:0] up, input logic [7:0] wd);
    join_addr = {up, wd};
  endfunction

  // Full received byte at this rising edge
  logic [7:0] rx_byte;
  assign rx_byte = {shreg[6:0], sda_sync[1]};

  // Array write strobe, same priority order as the engine below
  logic byte_wr;   // Last write-data bit sampled
  assign byte_wr = !o_busy && !stop_ev && !start_ev && (state == SEERP_WDATA) && scl_rise
                   && (bitcnt == SEERP_LAST_BIT);

  // Array write; no reset, contents stay undefined until written
  always_ff @(posedge i_ref_clk) begin
    if (byte_wr) begin
      mem[addr] <= rx_byte;
    end
  end

  // ==========================================================
  // Internal write cycle timer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr <= '0;
    end else if (stop_ev && wr_pend && tmr == '0) begin
      tmr <= SEERP_TMR_W'(TWR_CYCLES);
    end else if (tmr != '0) begin
      tmr <= tmr - 1'b1;
    end
  end
  assign o_busy = (tmr != '0);

  // ==========================================================
  // Protocol engine
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= SEERP_IDLE;
      ack_next  <= SEERP_IDLE;
      shreg     <= SEERP_BYTE_RST;
      bitcnt    <= SEERP_BIT_RST;
      addr      <= SEERP_ADDR_RST;
      upper     <= 3'h0;
      wr_pend   <= 1'b0;
      drive_low <= 1'b0;
      ack_held  <= 1'b0;
    end else if (o_busy) begin
      state     <= SEERP_IDLE;
      drive_low <= 1'b0;
      ack_held  <= 1'b0;
    end else if (stop_ev) begin
      state     <= SEERP_IDLE;
      drive_low <= 1'b0;
      ack_held  <= 1'b0;
      wr_pend   <= 1'b0;
    end else if (start_ev) begin
      state     <= SEERP_SADDR;
      bitcnt    <= SEERP_BIT_RST;
      drive_low <= 1'b0;
      ack_held  <= 1'b0;
    end else begin
      case (state)
        SEERP_SADDR, SEERP_WADDR, SEERP_WDATA: begin
          if (scl_rise) begin
            shreg  <= rx_byte;
            bitcnt <= bitcnt + 1'b1;
            if (bitcnt == SEERP_LAST_BIT) begin
              if (state == SEERP_SADDR) begin
                if (sa_match(rx_byte, cs_sync)) begin
                  upper <= rx_byte[SEERP_SA_UA_HI:SEERP_SA_UA_LO];
                  if (rx_byte[SEERP_SA_RW]) begin
                    ack_next <= SEERP_RDATA;
                  end else begin
                    ack_next <= SEERP_WADDR;
                  end
                  state <= SEERP_ACK;
                end else begin
                  state <= SEERP_IDLE;         // Not ours
                end
              end else if (state == SEERP_WADDR) begin
                addr     <= join_addr(upper, rx_byte);
                ack_next <= SEERP_WDATA;
                state    <= SEERP_ACK;
              end else begin
                addr      <= {addr[SEERP_ADDR_W-1:4], addr[3:0] + 4'h1 & SEERP_PAGE_MSK};
                wr_pend   <= 1'b1;
                ack_next  <= SEERP_WDATA;
                state     <= SEERP_ACK;
              end
            end
          end
        end
        SEERP_ACK: begin
          // Pull low on the fall after the eighth bit; on the next, release or drive the first read bit
          if (scl_fall) begin
            if (!ack_held) begin
              ack_held  <= 1'b1;
              drive_low <= 1'b1;
            end else begin
              ack_held <= 1'b0;
              bitcnt <= SEERP_BIT_RST;
              state  <= ack_next;
              if (ack_next == SEERP_RDATA) begin
                shreg     <= mem[addr];
                addr      <= addr + 1'b1;
                drive_low <= ~mem[addr][7];
              end else begin
                drive_low <= 1'b0;
              end
            end
          end
        end
        SEERP_RDATA: begin
          if (scl_fall) begin
            bitcnt <= bitcnt + 1'b1;
            if (bitcnt == SEERP_LAST_BIT) begin
              drive_low <= 1'b0;               // Release for master ack
              state     <= SEERP_MACK;
            end else begin
              shreg     <= {shreg[6:0], 1'b0};
              drive_low <= ~shreg[6];
            end
          end
        end
        SEERP_MACK: begin
          if (scl_rise) begin
            if (!sda_sync[1]) begin
              state <= SEERP_ACK;
              bitcnt <= SEERP_BIT_RST;
              ack_held <= 1'b1;                // Master acked, no slot of our own
            end else begin
              state <= SEERP_IDLE;
            end
          end
        end
        default: begin
          state <= SEERP_IDLE;
        end
      endcase
    end
  end

  // Open-drain data output, only ever low
  assign o_sda      = 1'b0;
  assign o_sda_oe_n = ~drive_low;

  // ==========================================================
  // Checks
  AST_NO_ACK_BUSY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_busy |=> o_sda_oe_n) else $error("Data driven while busy");
  AST_IGNORE_BUSY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_busy |=> state == SEERP_IDLE) else $error("Engine active while busy");
  AST_TIMER_LOAD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (stop_ev && wr_pend && !o_busy) |=> o_busy) else $error("Write cycle not started");
  AST_WRAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == SEERP_ACK && ack_next == SEERP_RDATA && scl_fall && ack_held && addr == SEERP_ADDR_MAX)
    |=> addr == SEERP_ADDR_RST) else $error("Counter did not wrap");
  AST_NACK_END: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == SEERP_MACK && scl_rise && sda_sync[1] && !stop_ev && !start_ev) |=> state == SEERP_IDLE)
    else $error("Read went on without acknowledge");
  AST_MACK_MORE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == SEERP_MACK && scl_rise && !sda_sync[1] && !stop_ev && !start_ev) |=> state == SEERP_ACK)
    else $error("Acknowledged read did not continue");
  AST_RELEASE_MACK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    state == SEERP_MACK |-> o_sda_oe_n) else $error("Line held in master ack slot");
  AST_LOW_ONLY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_sda_oe_n |-> (!o_sda && (state == SEERP_ACK || state == SEERP_RDATA)))
    else $error("Line driven high or outside a slot");
  AST_BAD_ADDR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == SEERP_SADDR && scl_rise && bitcnt == SEERP_LAST_BIT && !o_busy && !stop_ev && !start_ev
     && !sa_match(rx_byte, cs_sync)) |=> state == SEERP_IDLE) else $error("Foreign address taken");
endmodule
`default_nettype wire

// *** tb/seerp_master.sv ***
// Two-wire bus master model: drives the bus clock and its share of the data line.
// Assumes the bench resolves the data line as a pulled-up wired-AND.
`timescale 1ns/1ps
`default_nettype none
module seerp_master (
  // Bus pins
  output logic         o_scl,
  output logic         o_sda_m,
  input  wire logic    i_sda
);
  localparam realtime QTR = 31.25;  // Quarter of the 125 ns bus clock

  // Idle bus, both lines released
  initial begin
    o_scl   = 1'b1;
    o_sda_m = 1'b1;
  end

  // One bit slot: data moves while clock low, sampled mid-high
  task automatic xfer(input logic b, output logic s);
    o_scl = 1'b0;
    #QTR o_sda_m = b;
    #QTR o_scl = 1'b1;
    #QTR s = i_sda;
    #QTR;
  endtask

  // Start or repeated start, clock stays high after
  task automatic start();
    o_scl = 1'b0;
    #QTR o_sda_m = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_m = 1'b0;
    #QTR;
  endtask

  // Stop, bus left idle with the clock still
  task automatic stop();
    o_scl = 1'b0;
    #QTR o_sda_m = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_m = 1'b1;
    #QTR;
  endtask

  // Byte out MSB first, then release for the acknowledge slot
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(b[i], s);
    xfer(1'b1, s);
    ack = ~s;
  endtask

  // Byte in, then acknowledge to ask for more or release to end
  task automatic recv(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, s);
      b[i] = s;
    end
    xfer(~more, s);
  endtask
endmodule
`default_nettype wire

// *** tb/serial_eeprom_read_and_poll_tb.sv ***
// Bench for the serial EEPROM slave: writes, polling, reads, counter wrap.
// Assumes the bus master model drives the link; an array model predicts data.
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
  total_checks++; \
  if ((act) !== (exp)) begin \
    miscompares++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (act), (exp)); \
  end \
end
module serial_eeprom_read_and_poll_tb
  import seerp_pkg::*;
;
  logic       ref_clk, rst_n, scl, sda_m, sda_out, oe_n, busy;
  logic [2:0] sel;                 // Strap values
  logic [7:0] mem [SEERP_DEPTH];   // Array model
  logic [7:0] rnd = 8'h46;         // Random source state
  int         ctr, miscompares, total_checks;
  wire        sda = sda_m & (oe_n | sda_out);  // Pulled-up wired-AND

  seerp_slave #(.TWR_CYCLES(300)) i_seerp_slave (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
    .i_scl(scl), .i_sda(sda), .o_sda(sda_out), .o_sda_oe_n(oe_n),
    .i_chip_select_inputs(sel), .o_busy(busy));
  seerp_master i_seerp_master (.o_scl(scl), .o_sda_m(sda_m), .i_sda(sda));

  // ==========================================================
  // Helpers
  always #5 ref_clk = ~ref_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] sa(input logic [2:0] ua, input logic rw);
    return {1'b1, sel ^ SEERP_CS_INV, ua, rw};
  endfunction

  // New random straps, set just after a clock edge
  task automatic new_sel();
    @(posedge ref_clk);
    #1 rnd = lfsr(rnd);
    sel = rnd[2:0];
  endtask

  // Acknowledge polling until the write cycle ends
  task automatic poll_done();
    logic ack;
    int   n;
    n = 0;
    ack = 1'b0;
    while (!ack && n < 40) begin
      i_seerp_master.start();
      i_seerp_master.send(sa(3'h0, 1'b0), ack);
      i_seerp_master.stop();
      if (n == 0) `CHK(ack, 1'b0)
      n++;
    end
    `CHK(ack, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  // Page write of n random bytes, then polling
  task automatic wr(input logic [10:0] a, input int n);
    logic        ack;
    logic [10:0] p;
    new_sel();
    p = a;
    i_seerp_master.start();
    i_seerp_master.send(sa(a[10:8], 1'b0), ack);
    `CHK(ack, 1'b1)
    i_seerp_master.send(a[7:0], ack);
    `CHK(ack, 1'b1)
    repeat (n) begin
      rnd = lfsr(rnd);
      mem[p] = rnd;
      i_seerp_master.send(rnd, ack);
      p[3:0] = p[3:0] + 4'h1;
    end
    ctr = int'(p);
    i_seerp_master.stop();
    repeat (5) @(posedge ref_clk);
    `CHK(busy, 1'b1)
    poll_done();
  endtask

  // Random or current-address read of n bytes, compared with the model
  task automatic rd(input logic rand_rd, input logic [10:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    new_sel();
    i_seerp_master.start();
    if (rand_rd) begin
      i_seerp_master.send(sa(a[10:8], 1'b0), ack);
      i_seerp_master.send(a[7:0], ack);
      ctr = int'(a);
      i_seerp_master.start();
    end
    i_seerp_master.send(sa(3'(ctr >> 8), 1'b1), ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_seerp_master.recv(i < n - 1, d);
      `CHK(d, mem[ctr])
      ctr = (ctr + 1) % SEERP_DEPTH;
    end
    i_seerp_master.stop();
    repeat (5) @(posedge ref_clk);
    `CHK(oe_n, 1'b1)
    `CHK(sda_out, 1'b0)
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic ack;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    sel = 3'h0;
    ctr = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(11'h000, 4);
    rd(1'b1, 11'h001, 1);
    new_sel();
    i_seerp_master.start();
    i_seerp_master.send({1'b1, sel ^ SEERP_CS_INV ^ 3'h5, 3'h0, 1'b1}, ack);
    `CHK(ack, 1'b0)
    i_seerp_master.stop();
    rd(1'b0, 11'h000, 1);
    wr(11'h7fe, 2);
    rd(1'b1, 11'h7fe, 4);
    rd(1'b0, 11'h000, 2);
    tally_and_finish();
  end

  // Watchdog against a hung bus
  initial begin
    #400us;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
